// *** core/rss_reset_seq.sv ***
module rss_reset_seq
  import rss_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        wdt_ovf,
  input  wire logic        lvd_low,
  input  wire logic        supply_ok,
  input  wire logic        rst_pin_n,
  input  wire logic        pin_is_reset,
  input  wire logic        osc_stable,
  output logic             sys_rst,
  output logic             reg_init,
  output logic             osc_warm_en,
  output logic [12:0]      pc_start,
  output logic [1:0]       cpu_mode,
  output logic             reset_cause_flag_hi,
  output logic             reset_cause_flag_lo
);
  import rss_pkg::*;

  rss_src_if src ();

  rss_src_filter u_filt (
    .rst_pin_n    (rst_pin_n),
    .pin_is_reset (pin_is_reset),
    .wdt_ovf      (wdt_ovf),
    .lvd_low      (lvd_low),
    .src          (src)
  );
  assign src.pin_high = rst_pin_n;

  // ----------------------------------------
  // state and counters
  // ----------------------------------------
  rss_state_t       state_ff, nxt_state;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [1:0]       cause_ff, nxt_cause;
  logic             rel_ff;

  wire hold_cond  = src.any_hit | ~supply_ok;
  wire pin_block  = pin_is_reset & ~src.pin_high;
  wire init_done  = (cnt_ff == CNT_W'(INIT_CYC - 1));
  wire [1:0] hit_cause = src.pin_hit ? CAUSE_EXT :
                         src.wdt_hit ? CAUSE_WDT : CAUSE_POR;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_cause = cause_ff;
    if (src.any_hit) begin
      nxt_cause = hit_cause;
    end
    case (state_ff)
      ST_HOLD: begin
        nxt_cnt = '0;
        if (!hold_cond) begin
          nxt_state = ST_PIN_WAIT;
        end
      end
      ST_PIN_WAIT: begin
        if (hold_cond) begin
          nxt_state = ST_HOLD;
        end else if (!pin_block) begin
          nxt_state = ST_INIT;
        end
      end
      ST_INIT: begin
        nxt_cnt = cnt_ff + CNT_W'(1);
        if (hold_cond) begin
          nxt_state = ST_HOLD;
        end else if (init_done) begin
          nxt_state = ST_WARM;
        end
      end
      ST_WARM: begin
        if (hold_cond) begin
          nxt_state = ST_HOLD;
        end else if (osc_stable) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (hold_cond) begin
          nxt_state = ST_HOLD;
        end
      end
      default: nxt_state = ST_HOLD;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_HOLD;
      cnt_ff   <= '0;
      cause_ff <= CAUSE_RST_VAL;
    end else if (ce) begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      cause_ff <= nxt_cause;
    end
  end

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rel_ff <= 1'b0;
    end else if (ce) begin
      rel_ff <= (nxt_state == ST_RUN);
    end
  end

  assign sys_rst             = ~rel_ff | src.any_hit;
  assign reg_init            = (state_ff == ST_INIT);
  assign osc_warm_en         = (state_ff == ST_WARM);
  assign pc_start            = START_ADDR;
  assign cpu_mode            = MODE_NORMAL;
  assign reset_cause_flag_hi = cause_ff[CAUSE_HI_POS];
  assign reset_cause_flag_lo = cause_ff[CAUSE_LO_POS];
endmodule // rss_reset_seq

// *** core/rss_pkg.sv ***
// How it works
// - a watchdog overflow drives the sequencer into its reset state at once.
// - after a watchdog reset the sequencer hands back normal mode, never a low-power mode.
// - every sequence loads all system registers with initial values before warm-up starts.
// - after a stable clock is seen, reset is released and execution starts at address zero.
// - an uncleared watchdog keeps counting until it overflows, and the overflow resets.
// - a watchdog reset with a low supply stays in reset until the supply is valid again.
// - a low-voltage detect resets the whole system.
// - the reset pin is a reset source only when the pin option selects reset.
// - the reset pin is active low: high runs, low resets.
// - the reset pin works both during power-up and during normal running.
// - with the pin enabled, the sequence waits until the pin reads high, then initialises.
// - cause flags: 00 watchdog, 10 power-on or low voltage, 11 external reset.
package rss_pkg;
  // ----------------------------------------
  // timing and layout
  // ----------------------------------------
  localparam int          CLK_MHZ        = 50;
  localparam int          INIT_NS        = 200;
  localparam int          INIT_CYC       = (INIT_NS * CLK_MHZ + 999) / 1000;
  localparam int          CNT_W          = 8;
  localparam logic [12:0] START_ADDR     = 13'h0000;
  localparam logic [1:0]  CAUSE_WDT      = 2'h0;
  localparam logic [1:0]  CAUSE_POR      = 2'h2;
  localparam logic [1:0]  CAUSE_EXT      = 2'h3;
  localparam logic [1:0]  CAUSE_RST_VAL  = 2'h2;
  localparam int          CAUSE_HI_POS   = 1;
  localparam int          CAUSE_LO_POS   = 0;
  localparam logic [1:0]  MODE_NORMAL    = 2'h0;

  typedef enum logic [2:0] {
    ST_HOLD,
    ST_PIN_WAIT,
    ST_INIT,
    ST_WARM,
    ST_RUN
  } rss_state_t;
endpackage

// *** core/rss_src_if.sv ***
interface rss_src_if;
  logic wdt_hit;
  logic lvd_hit;
  logic pin_hit;
  logic any_hit;
  logic pin_high;
  modport filt (input pin_high, output wdt_hit, lvd_hit, pin_hit, any_hit);
  modport seq  (input wdt_hit, lvd_hit, pin_hit, any_hit, output pin_high);
endinterface

// *** core/rss_src_filter.sv ***
module rss_src_filter (
  input  wire logic rst_pin_n,
  input  wire logic pin_is_reset,
  input  wire logic wdt_ovf,
  input  wire logic lvd_low,
  rss_src_if.filt   src
);
  // ----------------------------------------
  // source qualification
  // ----------------------------------------
  wire pin_en = pin_is_reset;
  assign src.pin_hit  = pin_en & ~rst_pin_n;
  assign src.wdt_hit  = wdt_ovf;
  assign src.lvd_hit  = lvd_low;
  assign src.any_hit  = src.pin_hit | src.wdt_hit | src.lvd_hit;
endmodule // rss_src_filter

// *** test/rss_sva.sv ***
module rss_chk (
  input wire logic        mclk, rst, ce, wdt_ovf, lvd_low, supply_ok, rst_pin_n,
  input wire logic        pin_is_reset, osc_stable, sys_rst, reg_init, osc_warm_en,
  input wire logic [12:0] pc_start,
  input wire logic [1:0]  cpu_mode,
  input wire logic        reset_cause_flag_hi, reset_cause_flag_lo
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire pin_low = pin_is_reset && !rst_pin_n;
  a_wdt_forces_rst: assert property (wdt_ovf |-> sys_rst) else $error("wdt no reset");
  a_lvd_forces_rst: assert property (lvd_low |-> sys_rst) else $error("lvd no reset");
  a_pin_forces_rst: assert property (pin_low |-> sys_rst) else $error("pin no reset");
  a_pin_waits_high: assert property (pin_low && ce |=> sys_rst && !reg_init)
    else $error("init while pin low");
  a_init_then_warm: assert property ($rose(osc_warm_en) |-> $past(reg_init))
    else $error("warm without init");
  a_release_stable: assert property ($fell(sys_rst) |-> $past(osc_stable) && $past(osc_warm_en))
    else $error("release early");
  a_run_start_zero: assert property (!sys_rst |-> pc_start == 13'h0000 && cpu_mode == 2'h0)
    else $error("bad start");
  a_low_supply_hold: assert property (sys_rst && !supply_ok && ce |=> sys_rst)
    else $error("left reset on low supply");
  a_ext_cause_flags: assert property (pin_low && ce |=> reset_cause_flag_hi && reset_cause_flag_lo)
    else $error("ext flags");
  c_release: cover property ($fell(sys_rst));
  c_wdt: cover property (wdt_ovf);
  c_pin: cover property (pin_low);
endmodule // rss_chk
bind rss_reset_seq rss_chk CHK (.*);

// *** test/rss_supervisor.sv ***
module rss_supervisor #(parameter int DLY = 5) (
  input  wire logic mclk,
  input  wire logic hold,
  output logic      rst_pin_n
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  // pin low while held, high DLY cycles after
  always @(posedge mclk) cnt <= hold ? 0 : (cnt < DLY ? cnt + 1 : cnt);
  assign rst_pin_n = (cnt == DLY);
endmodule // rss_supervisor

// *** test/tb.sv ***
module tb import rss_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst = 1, ce = 1, wdt_ovf = 0, lvd_low = 0, supply_ok = 1;
  logic pin_is_reset = 1, osc_stable = 0, hold = 1, rst_pin_n, sys_rst, reg_init;
  logic osc_warm_en, reset_cause_flag_hi, reset_cause_flag_lo;
  logic [12:0] pc_start;
  logic [1:0] cpu_mode;
  int err_count = 0, n_tests = 0;
  wire [1:0] cause = {reset_cause_flag_hi, reset_cause_flag_lo};
  initial forever #10 mclk = ~mclk;
  rss_supervisor SUP (.mclk, .hold, .rst_pin_n);
  rss_reset_seq DUT (.*);
  task step(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task chk(input logic [12:0] got, input logic [12:0] exp);
    @(negedge mclk);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
    @(posedge mclk);
  endtask
  task stop_test;
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task run_wait;
    int i;
    step(16);
    osc_stable <= 1;
    for (i = 0; i < 200 && sys_rst !== 1'b0; i++) step(1);
    chk(sys_rst, 0);
    chk(pc_start, START_ADDR);
    chk(cpu_mode, MODE_NORMAL);
  endtask
  task t_por;
    step(30);
    chk(sys_rst, 1);
    hold <= 0;
    run_wait;
  endtask
  task t_wdt;
    wdt_ovf <= 1;
    osc_stable <= 0;
    step(1);
    wdt_ovf <= 0;
    step(1);
    chk(sys_rst, 1);
    run_wait;
    chk(cause, CAUSE_WDT);
  endtask
  task t_supply;
    supply_ok <= 0;
    wdt_ovf <= 1;
    step(1);
    wdt_ovf <= 0;
    step(40);
    chk(sys_rst, 1);
    supply_ok <= 1;
    osc_stable <= 0;
    run_wait;
    chk(cause, CAUSE_WDT);
  endtask
  task t_lvd;
    lvd_low <= 1;
    osc_stable <= 0;
    step(3);
    lvd_low <= 0;
    run_wait;
    chk(cause, CAUSE_POR);
  endtask
  task t_pin;
    pin_is_reset <= 0;
    hold <= 1;
    step(20);
    chk(sys_rst, 0);
    pin_is_reset <= 1;
    osc_stable <= 0;
    step(2);
    chk(sys_rst, 1);
    hold <= 0;
    run_wait;
    chk(cause, CAUSE_EXT);
  endtask
  initial begin
    step(20);
    rst <= 0;
    t_por;
    t_wdt;
    t_supply;
    t_lvd;
    t_pin;
    stop_test;
  end
  initial begin
    #100us;
    err_count++;
    stop_test;
  end
endmodule // tb
